// file: common/bscan_regs.vh
// Purpose: Constants for the boundary-scan test port.
// Assumes: Included by bare name from src files.
// Notes: Cell numbers run 1..144; cell 144 sits next to the data output.
`ifndef BSCAN_REGS_VH
`define BSCAN_REGS_VH

// ----------------------------------------
// Instruction register
// ----------------------------------------
`define IR_W 2
`define IR_EXTEST 2'h0
`define IR_SAMPLE_A 2'h1
`define IR_SAMPLE_B 2'h2
`define IR_BYPASS 2'h3
`define IR_RESET_VAL 2'h3
`define IR_CAPTURE_VAL 2'h1

// ----------------------------------------
// Boundary register shape
// ----------------------------------------
`define BSR_LEN 144
`define N_OBS 42
`define N_DRV 51
`define KIND_IN 2'h0
`define KIND_OUT 2'h1
`define KIND_TRI 2'h2

// ----------------------------------------
// Cell segments (last and first cell numbers)
// ----------------------------------------
`define SEG_A_END 60
`define SEG_B_END 70
`define SEG_C_END 76
`define SEG_D_END 100
`define SEG_E_END 132
`define SEG_B_FIRST 61
`define SEG_C_FIRST 71
`define SEG_D_FIRST 77
`define SEG_E_FIRST 101
`define SEG_F_FIRST 133

// ----------------------------------------
// Pin index bases per segment
// ----------------------------------------
`define OBS_B_BASE 20
`define OBS_D_BASE 30
`define OBS_F_BASE 38
`define DRV_C_BASE 20
`define DRV_D_BASE 23
`define DRV_E_BASE 31
`define DRV_F_BASE 47

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CELL_RESET_VAL 1'b0
`define BYPASS_CAPTURE_VAL 1'b0

`endif

// file: src/bscan_cell.v
// Purpose: One boundary-scan cell: shift stage plus update latch.
// Assumes: Strobes are single-cycle pulses on the system clock.
// Notes: Update latch clears to zero so all pins start released.
`timescale 1ns/1ps
`default_nettype none
`include "bscan_regs.vh"

module bscan_cell
(
   input wire clk_in,
   input wire rst_in,
   input wire capture_in,
   input wire shift_in,
   input wire update_in,
   input wire serial_in,
   input wire parallel_in,
   output wire serial_out,
   output wire update_out
);

   reg shift_ff;
   reg upd_ff;

   // ----------------------------------------
   // Shift stage and update latch
   // ----------------------------------------
   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         shift_ff <= `CELL_RESET_VAL;
         upd_ff <= `CELL_RESET_VAL;
      end
      else
      begin
         if (capture_in)
            shift_ff <= parallel_in;
         else if (shift_in)
            shift_ff <= serial_in;
         if (update_in)
            upd_ff <= shift_ff;
      end
   end

   assign serial_out = shift_ff;
   assign update_out = upd_ff;

endmodule
`default_nettype wire

// file: src/bscan_tap_top.v
// Purpose: Boundary-scan test port with 2-bit instruction, bypass and
//    144-cell boundary register.
// Assumes: Test port pins and pads are asynchronous to CLOCK_IN.
// Notes:
// Contract
// - The instruction register is exactly two bits, numbered zero and one.
// - Instruction bits shift in from the data input only in the shift-instruction state.
// - The current instruction picks the active data register and the scan path.
// - Code 00 selects the boundary register and drives every pin from it.
// - Codes 01 and 10 both select the boundary register with the core running.
// - Sample/preload captures live pins and lets shifted data load the update latches.
// - Code 11 puts the one-bit bypass register in the path with the core running.
// - Any test logic reset loads the bypass instruction.
// - Only the boundary and bypass data registers exist.
// - Every signal pin has a cell stage between core and pad that observes and controls.
// - The boundary register is 144 cells and cell 144 shifts out first.
// - Tristate cells are active high: one enables, zero releases.
// - All zeros in the boundary register release every driven pin.
// - Bidirectional pins get input, output and tristate cells, outputs get two, inputs one.
// - The port has a dedicated test reset input.
`timescale 1ns/1ps
`default_nettype none
`include "bscan_regs.vh"

module bscan_tap_top
#(
   parameter N_CELL = `BSR_LEN,
   parameter N_OBS = `N_OBS,
   parameter N_DRV = `N_DRV
)
(
   input wire CLOCK_IN,
   input wire RST_B_IN,
   input wire TCK_IN,
   input wire TMS_IN,
   input wire TDI_IN,
   input wire TRST_B_IN,
   output reg TDO_OUT,
   output reg TDO_OE_OUT,
   input wire [N_OBS-1:0] PAD_IN_IN,
   input wire [N_DRV-1:0] CORE_DATA_IN,
   input wire [N_DRV-1:0] CORE_OE_IN,
   output reg [N_DRV-1:0] PAD_DATA_OUT,
   output reg [N_DRV-1:0] PAD_OE_OUT,
   output reg [N_OBS-1:0] CORE_RX_OUT
);

   // ----------------------------------------
   // Port states
   // ----------------------------------------
   localparam [3:0] ST_TLR = 4'h0;
   localparam [3:0] ST_RTI = 4'h1;
   localparam [3:0] ST_SEL_DR = 4'h2;
   localparam [3:0] ST_CAP_DR = 4'h3;
   localparam [3:0] ST_SHF_DR = 4'h4;
   localparam [3:0] ST_EX1_DR = 4'h5;
   localparam [3:0] ST_PAU_DR = 4'h6;
   localparam [3:0] ST_EX2_DR = 4'h7;
   localparam [3:0] ST_UPD_DR = 4'h8;
   localparam [3:0] ST_SEL_IR = 4'h9;
   localparam [3:0] ST_CAP_IR = 4'hA;
   localparam [3:0] ST_SHF_IR = 4'hB;
   localparam [3:0] ST_EX1_IR = 4'hC;
   localparam [3:0] ST_PAU_IR = 4'hD;
   localparam [3:0] ST_EX2_IR = 4'hE;
   localparam [3:0] ST_UPD_IR = 4'hF;

   // ----------------------------------------
   // Cell map: {kind, pad index, drive index}
   // ----------------------------------------
   function [13:0] cell_info;
      input integer c;
      integer p;
      integer k;
      integer o;
      integer d;
      begin
         p = 0;
         k = 0;
         o = 0;
         d = 0;
         if (c <= `SEG_A_END)
         begin
            p = (c - 1) / 3;
            k = (c - 1) % 3;
            o = p;
            d = p;
         end
         else if (c <= `SEG_B_END)
         begin
            o = `OBS_B_BASE + c - `SEG_B_FIRST;
         end
         else if (c <= `SEG_C_END)
         begin
            p = (c - `SEG_C_FIRST) / 2;
            k = (c - `SEG_C_FIRST) % 2 + 1;
            d = `DRV_C_BASE + p;
         end
         else if (c <= `SEG_D_END)
         begin
            p = (c - `SEG_D_FIRST) / 3;
            k = (c - `SEG_D_FIRST) % 3;
            o = `OBS_D_BASE + p;
            d = `DRV_D_BASE + p;
         end
         else if (c <= `SEG_E_END)
         begin
            p = (c - `SEG_E_FIRST) / 2;
            k = (c - `SEG_E_FIRST) % 2 + 1;
            d = `DRV_E_BASE + p;
         end
         else
         begin
            p = (c - `SEG_F_FIRST) / 3;
            k = (c - `SEG_F_FIRST) % 3;
            o = `OBS_F_BASE + p;
            d = `DRV_F_BASE + p;
         end
         cell_info = {k[1:0], o[5:0], d[5:0]};
      end
   endfunction

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   reg [3:0] pin_s1_ff;
   reg [3:0] pin_s2_ff;
   reg tck_d_ff;
   reg [N_OBS-1:0] pad_s1_ff;
   reg [N_OBS-1:0] pad_s2_ff;
   reg [3:0] state_ff;
   reg [3:0] nxt_state;
   reg [`IR_W-1:0] ir_ff;
   reg [`IR_W-1:0] ir_sh_ff;
   reg bypass_ff;
   reg nxt_tdo;
   wire tck_s;
   wire tms_s;
   wire tdi_s;
   wire trst_b_s;
   wire tck_rise;
   wire tck_fall;
   wire test_rst;
   wire cell_rst;
   wire sel_bsr;
   wire extest;
   wire bsr_cap;
   wire bsr_shf;
   wire bsr_upd;
   wire [N_CELL:0] chain;
   wire [N_OBS-1:0] in_upd;
   wire [N_DRV-1:0] drv_upd_d;
   wire [N_DRV-1:0] drv_upd_oe;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   always @(posedge CLOCK_IN)
   begin
      if (!RST_B_IN)
      begin
         pin_s1_ff <= 4'h0;
         pin_s2_ff <= 4'h0;
         tck_d_ff <= 1'b0;
         pad_s1_ff <= {N_OBS{1'b0}};
         pad_s2_ff <= {N_OBS{1'b0}};
      end
      else
      begin
         pin_s1_ff <= {TRST_B_IN, TDI_IN, TMS_IN, TCK_IN};
         pin_s2_ff <= pin_s1_ff;
         tck_d_ff <= pin_s2_ff[0];
         pad_s1_ff <= PAD_IN_IN;
         pad_s2_ff <= pad_s1_ff;
      end
   end

   assign tck_s = pin_s2_ff[0];
   assign tms_s = pin_s2_ff[1];
   assign tdi_s = pin_s2_ff[2];
   assign trst_b_s = pin_s2_ff[3];
   assign tck_rise = tck_s & ~tck_d_ff;
   assign tck_fall = ~tck_s & tck_d_ff;
   assign test_rst = ~trst_b_s;

   // ----------------------------------------
   // Port state machine
   // ----------------------------------------
   always @*
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_TLR: nxt_state = tms_s ? ST_TLR : ST_RTI;
         ST_RTI: nxt_state = tms_s ? ST_SEL_DR : ST_RTI;
         ST_SEL_DR: nxt_state = tms_s ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: nxt_state = tms_s ? ST_EX1_DR : ST_SHF_DR;
         ST_SHF_DR: nxt_state = tms_s ? ST_EX1_DR : ST_SHF_DR;
         ST_EX1_DR: nxt_state = tms_s ? ST_UPD_DR : ST_PAU_DR;
         ST_PAU_DR: nxt_state = tms_s ? ST_EX2_DR : ST_PAU_DR;
         ST_EX2_DR: nxt_state = tms_s ? ST_UPD_DR : ST_SHF_DR;
         ST_UPD_DR: nxt_state = tms_s ? ST_SEL_DR : ST_RTI;
         ST_SEL_IR: nxt_state = tms_s ? ST_TLR : ST_CAP_IR;
         ST_CAP_IR: nxt_state = tms_s ? ST_EX1_IR : ST_SHF_IR;
         ST_SHF_IR: nxt_state = tms_s ? ST_EX1_IR : ST_SHF_IR;
         ST_EX1_IR: nxt_state = tms_s ? ST_UPD_IR : ST_PAU_IR;
         ST_PAU_IR: nxt_state = tms_s ? ST_EX2_IR : ST_PAU_IR;
         ST_EX2_IR: nxt_state = tms_s ? ST_UPD_IR : ST_SHF_IR;
         ST_UPD_IR: nxt_state = tms_s ? ST_SEL_DR : ST_RTI;
         default: nxt_state = ST_TLR;
      endcase
   end

   always @(posedge CLOCK_IN)
   begin
      if (!RST_B_IN || test_rst)
         state_ff <= ST_TLR;
      else if (tck_rise)
         state_ff <= nxt_state;
   end

   // ----------------------------------------
   // Instruction register
   // ----------------------------------------
   always @(posedge CLOCK_IN)
   begin
      if (!RST_B_IN || test_rst || state_ff == ST_TLR)
      begin
         ir_ff <= `IR_RESET_VAL;
         ir_sh_ff <= `IR_RESET_VAL;
      end
      else if (tck_rise)
      begin
         if (state_ff == ST_CAP_IR)
            ir_sh_ff <= `IR_CAPTURE_VAL;
         else if (state_ff == ST_SHF_IR)
            ir_sh_ff <= {tdi_s, ir_sh_ff[1]};
         else if (state_ff == ST_UPD_IR)
            ir_ff <= ir_sh_ff;
      end
   end

   // ----------------------------------------
   // Instruction decode
   // ----------------------------------------
   assign extest = (ir_ff == `IR_EXTEST);
   assign sel_bsr = (ir_ff != `IR_BYPASS);
   assign bsr_cap = tck_rise & sel_bsr & (state_ff == ST_CAP_DR);
   assign bsr_shf = tck_rise & sel_bsr & (state_ff == ST_SHF_DR);
   assign bsr_upd = tck_rise & sel_bsr & (state_ff == ST_UPD_DR);
   assign cell_rst = ~RST_B_IN | test_rst | (state_ff == ST_TLR);

   // ----------------------------------------
   // Bypass register
   // ----------------------------------------
   always @(posedge CLOCK_IN)
   begin
      if (!RST_B_IN)
         bypass_ff <= `BYPASS_CAPTURE_VAL;
      else if (tck_rise && !sel_bsr)
      begin
         if (state_ff == ST_CAP_DR)
            bypass_ff <= `BYPASS_CAPTURE_VAL;
         else if (state_ff == ST_SHF_DR)
            bypass_ff <= tdi_s;
      end
   end

   // ----------------------------------------
   // Boundary register
   // ----------------------------------------
   assign chain[0] = tdi_s;

   genvar g;
   generate
      for (g = 0; g < N_CELL; g = g + 1)
      begin : cells
         localparam [13:0] INFO = cell_info(g + 1);
         localparam [1:0] KIND = INFO[13:12];
         localparam [5:0] OBS = INFO[11:6];
         localparam [5:0] DRV = INFO[5:0];
         wire par;
         wire upd;
         if (KIND == `KIND_IN)
         begin : k_in
            assign par = pad_s2_ff[OBS];
            assign in_upd[OBS] = upd;
         end
         else if (KIND == `KIND_OUT)
         begin : k_out
            assign par = CORE_DATA_IN[DRV];
            assign drv_upd_d[DRV] = upd;
         end
         else
         begin : k_tri
            assign par = CORE_OE_IN[DRV];
            assign drv_upd_oe[DRV] = upd;
         end
         bscan_cell u_cell
         (
            .clk_in(CLOCK_IN),
            .rst_in(cell_rst),
            .capture_in(bsr_cap),
            .shift_in(bsr_shf),
            .update_in(bsr_upd),
            .serial_in(chain[g]),
            .parallel_in(par),
            .serial_out(chain[g + 1]),
            .update_out(upd)
         );
      end
   endgenerate

   // ----------------------------------------
   // Pad and core drive
   // ----------------------------------------
   always @(posedge CLOCK_IN)
   begin
      if (!RST_B_IN)
      begin
         PAD_DATA_OUT <= {N_DRV{1'b0}};
         PAD_OE_OUT <= {N_DRV{1'b0}};
         CORE_RX_OUT <= {N_OBS{1'b0}};
      end
      else if (extest)
      begin
         PAD_DATA_OUT <= drv_upd_d;
         PAD_OE_OUT <= drv_upd_oe;
         CORE_RX_OUT <= in_upd;
      end
      else
      begin
         PAD_DATA_OUT <= CORE_DATA_IN;
         PAD_OE_OUT <= CORE_OE_IN;
         CORE_RX_OUT <= pad_s2_ff;
      end
   end

   // ----------------------------------------
   // Serial output on falling test clock
   // ----------------------------------------
   always @*
   begin
      nxt_tdo = 1'b0;
      if (state_ff == ST_SHF_IR)
         nxt_tdo = ir_sh_ff[0];
      else if (sel_bsr)
         nxt_tdo = chain[N_CELL];
      else
         nxt_tdo = bypass_ff;
   end

   always @(posedge CLOCK_IN)
   begin
      if (!RST_B_IN)
      begin
         TDO_OUT <= 1'b0;
         TDO_OE_OUT <= 1'b0;
      end
      else if (tck_fall)
      begin
         TDO_OUT <= nxt_tdo;
         TDO_OE_OUT <= (state_ff == ST_SHF_IR) || (state_ff == ST_SHF_DR);
      end
   end

endmodule
`default_nettype wire

// file: verification/bscan_tap_properties.sv
// Purpose: Port-level checks for the boundary-scan test port.
// Assumes: Test clock phases last at least four system clocks.
// Notes: Bound to bscan_tap_top below.
`timescale 1ns/1ps
`default_nettype none

module bscan_tap_properties
#(
   parameter N_OBS = 42,
   parameter N_DRV = 51
)
(
   input wire logic CLOCK_IN,
   input wire logic RST_B_IN,
   input wire logic TCK_IN,
   input wire logic TMS_IN,
   input wire logic TDI_IN,
   input wire logic TRST_B_IN,
   input wire logic TDO_OUT,
   input wire logic TDO_OE_OUT,
   input wire logic [N_OBS-1:0] PAD_IN_IN,
   input wire logic [N_DRV-1:0] CORE_DATA_IN,
   input wire logic [N_DRV-1:0] CORE_OE_IN,
   input wire logic [N_DRV-1:0] PAD_DATA_OUT,
   input wire logic [N_DRV-1:0] PAD_OE_OUT,
   input wire logic [N_OBS-1:0] CORE_RX_OUT
);
   default clocking cb @(posedge CLOCK_IN);
   endclocking
   default disable iff (!RST_B_IN || !TRST_B_IN);

   // ----------------------------------------
   // Serial port timing
   // ----------------------------------------
   AST_TDO_ON_FALL: assert property (
      $changed(TDO_OUT) |-> !$past(TCK_IN, 3)) else $error("tdo moved in high phase");
   AST_OE_AFTER_HIGH: assert property (
      $changed(TDO_OE_OUT) |-> $past(TCK_IN, 5) || $past(TCK_IN, 6))
      else $error("tdo enable moved without a clock pulse");
   AST_TDO_STANDS_HIGH: assert property (
      $rose(TCK_IN) |=> $stable(TDO_OUT)[*3]) else $error("tdo unstable in high phase");
   AST_OE_MIN_SPAN: assert property (
      $rose(TDO_OE_OUT) |-> TDO_OE_OUT[*4]) else $error("shift window too short");

   // ----------------------------------------
   // Resets and pin paths
   // ----------------------------------------
   AST_RESET_CLEARS: assert property (disable iff (1'h0)
      !RST_B_IN |=> !TDO_OUT && !TDO_OE_OUT && PAD_OE_OUT == '0 && CORE_RX_OUT == '0)
      else $error("outputs not cleared by reset");
   AST_TRST_PADS_FOLLOW: assert property (disable iff (!RST_B_IN)
      !TRST_B_IN[*6] |-> PAD_DATA_OUT == $past(CORE_DATA_IN) && PAD_OE_OUT == $past(CORE_OE_IN))
      else $error("pads not from core in test reset");
   AST_TRST_RX_FOLLOW: assert property (disable iff (!RST_B_IN)
      (!TRST_B_IN && $stable(PAD_IN_IN))[*6] |-> CORE_RX_OUT == PAD_IN_IN)
      else $error("core rx not from pads in test reset");
   AST_PADS_QUIET: assert property (
      ($stable(CORE_DATA_IN) && $stable(CORE_OE_IN) && !TCK_IN)[*8]
      |-> $stable(PAD_DATA_OUT) && $stable(PAD_OE_OUT)) else $error("pads moved unprompted");

   COV_SHIFT: cover property ($rose(TDO_OE_OUT));
   COV_RELEASED: cover property (PAD_OE_OUT == '0 && CORE_OE_IN != '0);
   COV_TRST: cover property (disable iff (!RST_B_IN) $fell(TRST_B_IN));
endmodule

bind bscan_tap_top bscan_tap_properties #(.N_OBS(N_OBS), .N_DRV(N_DRV)) u_bscan_tap_properties (
   .CLOCK_IN, .RST_B_IN, .TCK_IN, .TMS_IN, .TDI_IN, .TRST_B_IN, .TDO_OUT, .TDO_OE_OUT,
   .PAD_IN_IN, .CORE_DATA_IN, .CORE_OE_IN, .PAD_DATA_OUT, .PAD_OE_OUT, .CORE_RX_OUT);

`default_nettype wire

// file: verification/jtag_ctl_model.sv
// Purpose: Board test controller driving the test access port.
// Assumes: Test clock 160 ns period, stopped low between scans.
// Notes: Data and mode lines rest high after each scan.
`timescale 1ns/1ps
`default_nettype none

module jtag_ctl_model
(
   output logic tck_out,
   output logic tms_out,
   output logic tdi_out,
   output logic trst_b_out,
   input wire logic tdo_in
);
   initial
   begin
      tck_out = 1'h0;
      tms_out = 1'h1;
      tdi_out = 1'h1;
      trst_b_out = 1'h1;
   end

   // One test clock period; data out taken before the next fall
   task automatic tick(input logic m, input logic d, output logic q);
      tms_out = m;
      tdi_out = d;
      #80 tck_out = 1'h1;
      #80 q = tdo_in;
      tck_out = 1'h0;
   endtask

   // Scan from idle back to idle
   task automatic scan(input logic ir, input int len, input logic [143:0] din,
      output logic [143:0] dout);
      int k;
      logic q;
      dout = 144'h0;
      #7;
      tick(1'h1, 1'h1, q);
      if (ir)
         tick(1'h1, 1'h1, q);
      tick(1'h0, 1'h1, q);
      tick(1'h0, 1'h1, q);
      for (int i = 0; i < len; i++)
      begin
         k = ir ? i : len - 1 - i;
         tick(i == len - 1, din[k], dout[k]);
      end
      tick(1'h1, 1'h1, q);
      tick(1'h0, 1'h1, q);
      tms_out = 1'h1;
      tdi_out = 1'h1;
   endtask

   task automatic reset_tap();
      logic q;
      repeat (5) tick(1'h1, 1'h1, q);
      tick(1'h0, 1'h1, q);
   endtask

   task automatic test_reset();
      trst_b_out = 1'h0;
      #200 trst_b_out = 1'h1;
   endtask
endmodule

`default_nettype wire

// file: verification/testbench.sv
// Purpose: Self-checking bench for the boundary-scan test port.
// Assumes: Pins and core driven at the falling system clock edge.
// Notes: Random pin values come from a fixed-seed shift register.
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic clk = 1'h0;
   logic rst_b = 1'h0;
   logic [41:0] pad_in = 42'h0;
   logic [50:0] core_data = 51'h0;
   logic [50:0] core_oe = 51'h0;
   logic [31:0] lfsr = 32'h0000000B;
   logic [143:0] got;
   logic [143:0] pre;
   logic [41:0] p_obs;
   logic [50:0] p_dat;
   logic [50:0] p_oe;
   int num_errors = 0;
   int n_compared = 0;
   wire tck, tms, tdi, trst_b, tdo, tdo_oe;
   wire [50:0] pad_data;
   wire [50:0] pad_oe;
   wire [41:0] core_rx;

   always #10 clk = ~clk;

   bscan_tap_top u_bscan_tap_top (.CLOCK_IN(clk), .RST_B_IN(rst_b), .TCK_IN(tck),
      .TMS_IN(tms), .TDI_IN(tdi), .TRST_B_IN(trst_b), .TDO_OUT(tdo), .TDO_OE_OUT(tdo_oe),
      .PAD_IN_IN(pad_in), .CORE_DATA_IN(core_data), .CORE_OE_IN(core_oe),
      .PAD_DATA_OUT(pad_data), .PAD_OE_OUT(pad_oe), .CORE_RX_OUT(core_rx));

   jtag_ctl_model u_jtag_ctl_model (.tck_out(tck), .tms_out(tms), .tdi_out(tdi),
      .trst_b_out(trst_b), .tdo_in(tdo));

   // ----------------------------------------
   // Expectation helpers
   // ----------------------------------------
   function automatic [31:0] lfsr_next(input logic [31:0] s);
      lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Cell image from pin values; index is cell number minus one
   function automatic [143:0] mk(input logic [41:0] o, input logic [50:0] d,
      input logic [50:0] e);
      mk = 144'h0;
      for (int j = 0; j < 20; j++)
         {mk[3*j+2], mk[3*j+1], mk[3*j]} = {e[j], d[j], o[j]};
      for (int j = 0; j < 10; j++)
         mk[60+j] = o[20+j];
      for (int j = 0; j < 3; j++)
         {mk[71+2*j], mk[70+2*j]} = {e[20+j], d[20+j]};
      for (int j = 0; j < 8; j++)
         {mk[78+3*j], mk[77+3*j], mk[76+3*j]} = {e[23+j], d[23+j], o[30+j]};
      for (int j = 0; j < 16; j++)
         {mk[101+2*j], mk[100+2*j]} = {e[31+j], d[31+j]};
      for (int j = 0; j < 4; j++)
         {mk[134+3*j], mk[133+3*j], mk[132+3*j]} = {e[47+j], d[47+j], o[38+j]};
   endfunction

   task automatic roll(output logic [63:0] r);
      lfsr = lfsr_next(lfsr);
      r[31:0] = lfsr;
      lfsr = lfsr_next(lfsr);
      r[63:32] = lfsr;
   endtask

   task automatic rand_pins();
      logic [63:0] r;
      @(negedge clk);
      roll(r);
      pad_in = r[41:0];
      roll(r);
      core_data = r[50:0];
      roll(r);
      core_oe = r[50:0];
   endtask

   task automatic new_pre();
      logic [63:0] r;
      roll(r);
      p_obs = r[41:0];
      roll(r);
      p_dat = r[50:0];
      roll(r);
      p_oe = r[50:0];
      pre = mk(p_obs, p_dat, p_oe);
   endtask

   task automatic check(input logic [143:0] seen, input logic [143:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic follow();
      repeat (8) @(negedge clk);
      check({pad_data, pad_oe, core_rx}, {core_data, core_oe, pad_in});
   endtask

   task automatic drive_check();
      repeat (8) @(negedge clk);
      check({pad_data, pad_oe, core_rx}, {p_dat, p_oe, p_obs});
   endtask

   task automatic load_ir(input logic [1:0] code);
      u_jtag_ctl_model.scan(1'h1, 2, {142'h0, code}, got);
      check(got, 144'h1);
   endtask

   task automatic print_verdict();
      $display("checks %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (4) @(negedge clk);
      rst_b = 1'h1;
      repeat (4) @(negedge clk);
      rand_pins();
      u_jtag_ctl_model.reset_tap();
      u_jtag_ctl_model.scan(1'h0, 8, 144'hB4, got);
      check(got, 144'h5A);
      follow();
      for (int c = 1; c < 3; c++)
      begin
         load_ir(c[1:0]);
         rand_pins();
         follow();
         new_pre();
         u_jtag_ctl_model.scan(1'h0, 144, pre, got);
         check(got, mk(pad_in, core_data, core_oe));
         follow();
      end
      load_ir(2'h0);
      rand_pins();
      drive_check();
      u_jtag_ctl_model.reset_tap();
      follow();
      load_ir(2'h0);
      repeat (8) @(negedge clk);
      check(pad_oe, 51'h0);
      new_pre();
      u_jtag_ctl_model.scan(1'h0, 144, pre, got);
      drive_check();
      u_jtag_ctl_model.scan(1'h0, 144, 144'h0, got);
      check(got, mk(pad_in, core_data, core_oe));
      repeat (8) @(negedge clk);
      check({pad_data, pad_oe}, 102'h0);
      load_ir(2'h3);
      u_jtag_ctl_model.scan(1'h0, 8, 144'hB4, got);
      check(got, 144'h5A);
      follow();
      u_jtag_ctl_model.test_reset();
      follow();
      print_verdict();
   end

   initial
   begin
      #1000000;
      num_errors++;
      print_verdict();
   end
endmodule

`default_nettype wire
